// >>> verilog/tro_pkg.sv
// Package with constants and types of the thermal replica block.
`default_nettype none
package tro_pkg;
	localparam int unsigned CLK_HZ        = 100000000;
	localparam int unsigned CYCLE_US      = 5000;
	localparam int unsigned CYCLE_CLKS    = CYCLE_US * (CLK_HZ / 1000000);
	localparam int unsigned STEP_MS       = 5;
	localparam int unsigned TAU_MS_PER_MN = 60000;
	localparam int unsigned CUR_W         = 16;
	localparam int unsigned FAC_W         = 16;
	localparam int unsigned FAC_FRAC      = 12;
	localparam int unsigned TMP_W         = 12;
	localparam int unsigned IMG_W         = 24;
	localparam int unsigned IMG_FRAC      = 16;
	localparam int unsigned CURVE_PTS     = 10;
	localparam int unsigned CURVE_MIN     = 2;
	localparam logic [15:0] FAC_ONE       = 16'h1000;
	localparam logic [11:0] TREF_DEF_C    = 12'h00F;
	localparam logic [23:0] IMG_RESET     = 24'h000000;
	localparam logic [23:0] PCT_100       = 24'h640000;
	typedef enum logic [2:0] {
		TRO_IDLE  = 3'b000,
		TRO_MAXI  = 3'b001,
		TRO_AMB   = 3'b010,
		TRO_RATIO = 3'b011,
		TRO_DECAY = 3'b100,
		TRO_STORE = 3'b101
	} tro_state_e;
endpackage
`default_nettype wire

// >>> verilog/tro_amb_if.sv
// Interface carrying the ambient factor request and answer.
`timescale 1ns/1ps
`default_nettype none
interface tro_amb_if;
	logic signed [11:0] t_amb;
	logic        [15:0] k_amb;
	modport core (output t_amb, input k_amb);
	modport calc (input t_amb, output k_amb);
endinterface
`default_nettype wire

// >>> verilog/tro_amb_calc.sv
// Ambient temperature correction factor, linear or curve mode.
`timescale 1ns/1ps
`default_nettype none
module tro_amb_calc #(
	parameter int NPTS = tro_pkg::CURVE_PTS
) (
	input  wire logic                  clk,
	input  wire logic                  rst,
	input  wire logic                  ce,
	input  wire logic                  curve_mode,
	input  wire logic signed [11:0]    t_min,
	input  wire logic signed [11:0]    t_ref,
	input  wire logic signed [11:0]    t_max,
	input  wire logic        [15:0]    k_min,
	input  wire logic        [15:0]    k_max,
	input  wire logic        [3:0]     pts_used,
	input  wire logic signed [11:0]    crv_t [NPTS],
	input  wire logic        [15:0]    crv_k [NPTS],
	tro_amb_if.calc                    amb
);
	logic [15:0] k_r;
	logic [15:0] k_nxt;

	function automatic logic [15:0] lerp(input logic signed [11:0] x,
		input logic signed [11:0] x0, input logic signed [11:0] x1,
		input logic [15:0] y0, input logic [15:0] y1);
		logic signed [31:0] num;
		logic signed [31:0] res;
		num = (32'(signed'({1'b0, y1})) - 32'(signed'({1'b0, y0})))
			* (32'(x) - 32'(x0));
		res = (x1 == x0) ? 32'(signed'({1'b0, y0}))
			: num / (32'(x1) - 32'(x0)) + 32'(signed'({1'b0, y0}));
		lerp = (res < 0) ? 16'h0000 : res[15:0];
	endfunction

	always_comb begin
		logic [3:0] n;
		n = (pts_used < 4'(tro_pkg::CURVE_MIN)) ? 4'(tro_pkg::CURVE_MIN)
			: (pts_used > 4'(NPTS)) ? 4'(NPTS) : pts_used;
		k_nxt = k_r;
		if (!curve_mode) begin
			if (amb.t_amb <= t_min)
				k_nxt = k_min;
			else if (amb.t_amb >= t_max)
				k_nxt = k_max;
			else if (amb.t_amb < t_ref)
				k_nxt = lerp(amb.t_amb, t_min, t_ref, k_min,
					tro_pkg::FAC_ONE);
			else
				k_nxt = lerp(amb.t_amb, t_ref, t_max,
					tro_pkg::FAC_ONE, k_max);
		end else begin
			if (amb.t_amb <= crv_t[0])
				k_nxt = crv_k[0];
			else
				k_nxt = crv_k[n - 4'h1];
			for (int i = NPTS - 1; i >= 1; i--) begin
				if (4'(i) < n && amb.t_amb > crv_t[i-1]
					&& amb.t_amb <= crv_t[i])
					k_nxt = lerp(amb.t_amb, crv_t[i-1], crv_t[i],
						crv_k[i-1], crv_k[i]);
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst)
			k_r <= tro_pkg::FAC_ONE;
		else if (ce)
			k_r <= k_nxt;
	end

	assign amb.k_amb = k_r;

	amb_clamp_a: assert property (@(posedge clk) disable iff (rst)
		ce && !curve_mode && amb.t_amb <= t_min && t_min < t_max
		|=> k_r == $past(k_min)) else $error("low clamp wrong");
endmodule
`default_nettype wire

// >>> verilog/tro_core.sv
// Thermal replica overload filter, top module.
`timescale 1ns/1ps
`default_nettype none
module tro_core #(
	parameter int CYCLE_CLKS = tro_pkg::CYCLE_CLKS,
	parameter int NPTS       = tro_pkg::CURVE_PTS
) (
	input  wire logic               CLK,
	input  wire logic               RST,
	input  wire logic               CE,
	input  wire logic [15:0]        I_L1,
	input  wire logic [15:0]        I_L2,
	input  wire logic [15:0]        I_L3,
	input  wire logic [15:0]        I_NOM,
	input  wire logic [15:0]        K_SF,
	input  wire logic [15:0]        TAU_MIN,
	input  wire logic               AMB_FIXED,
	input  wire logic signed [11:0] T_SENSOR,
	input  wire logic signed [11:0] T_SET,
	input  wire logic               TEMP_FAHR,
	input  wire logic signed [11:0] T_MIN,
	input  wire logic signed [11:0] T_REF,
	input  wire logic signed [11:0] T_MAX,
	input  wire logic [15:0]        K_MIN,
	input  wire logic [15:0]        K_MAX,
	input  wire logic               CURVE_MODE,
	input  wire logic [3:0]         CURVE_PTS_USED,
	input  wire logic signed [11:0] CURVE_T [NPTS],
	input  wire logic [15:0]        CURVE_K [NPTS],
	output logic [23:0]             THERMAL_IMAGE,
	output logic [15:0]             K_AMB,
	output logic                    CYCLE_DONE
);
	logic [$clog2(CYCLE_CLKS)-1:0] cnt_r;
	logic [$clog2(CYCLE_CLKS)-1:0] cnt_nxt;
	tro_pkg::tro_state_e           st_r;
	tro_pkg::tro_state_e           st_nxt;
	logic [15:0]                   imax_r;
	logic [15:0]                   imax_nxt;
	logic [23:0]                   ratio_r;
	logic [23:0]                   ratio_nxt;
	logic [23:0]                   img_r;
	logic [23:0]                   img_nxt;
	logic [15:0]                   kamb_r;
	logic [15:0]                   kamb_nxt;
	logic [15:0]                   decay_r;
	logic [15:0]                   decay_nxt;
	logic                          done_r;
	logic                          done_nxt;
	logic signed [11:0]            tsens_s1;
	logic signed [11:0]            tsens_s2;
	tro_amb_if                     amb ();
	localparam int                 GW = $clog2(CYCLE_CLKS) + 1;
	logic [GW-1:0]                 gap_r;
	logic [GW-1:0]                 gap_nxt;
	logic                          seen_r;
	logic                          seen_nxt;

	function automatic logic signed [11:0] to_c(input logic signed [11:0] t,
		input logic fahr);
		logic signed [23:0] w;
		w = ((24'(t) - 24'sd32) * 24'sd5) / 24'sd9;
		to_c = fahr ? w[11:0] : t;
	endfunction

	function automatic logic [15:0] max3(input logic [15:0] a,
		input logic [15:0] b, input logic [15:0] c);
		logic [15:0] m;
		m = (a > b) ? a : b;
		max3 = (m > c) ? m : c;
	endfunction

	always_ff @(posedge CLK) begin
		if (CE) begin
			tsens_s1 <= T_SENSOR;
			tsens_s2 <= tsens_s1;
		end
	end

	assign amb.t_amb = to_c(AMB_FIXED ? T_SET : tsens_s2, TEMP_FAHR);

	tro_amb_calc #(.NPTS(NPTS)) u_amb (
		.clk        (CLK),
		.rst        (RST),
		.ce         (CE),
		.curve_mode (CURVE_MODE),
		.t_min      (to_c(T_MIN, TEMP_FAHR)),
		.t_ref      (to_c(T_REF, TEMP_FAHR)),
		.t_max      (to_c(T_MAX, TEMP_FAHR)),
		.k_min      (K_MIN),
		.k_max      (K_MAX),
		.pts_used   (CURVE_PTS_USED),
		.crv_t      (CURVE_T),
		.crv_k      (CURVE_K),
		.amb        (amb)
	);

	always_comb begin
		logic [47:0] den;
		logic [47:0] q;
		logic [47:0] sq;
		logic [47:0] tau_ms;
		logic [47:0] e;
		logic signed [48:0] d;
		den = 48'(I_NOM) * 48'(K_SF) * 48'(kamb_r) >> (2 * tro_pkg::FAC_FRAC);
		q   = (den == 48'h0) ? 48'h0 : (48'(imax_r) << 12) / den;
		// A huge ratio would wrap the square, so it saturates first.
		sq  = (q > 48'h00FFFF) ? 48'h000001000000
			: (q * q * 48'd100) >> 8;
		tau_ms = 48'(TAU_MIN) * 48'(tro_pkg::TAU_MS_PER_MN);
		e   = (tau_ms == 48'h0) ? 48'h0
			: 48'h10000 - (48'(tro_pkg::STEP_MS) << 16) / tau_ms;
		d   = 49'(signed'({1'b0, img_r})) - 49'(signed'({1'b0, ratio_r}));
		cnt_nxt   = cnt_r;
		st_nxt    = st_r;
		imax_nxt  = imax_r;
		ratio_nxt = ratio_r;
		img_nxt   = img_r;
		kamb_nxt  = kamb_r;
		decay_nxt = decay_r;
		done_nxt  = 1'b0;
		unique case (st_r)
			tro_pkg::TRO_IDLE: begin
				if (cnt_r == ($clog2(CYCLE_CLKS))'(CYCLE_CLKS - 1)) begin
					cnt_nxt = '0;
					st_nxt  = tro_pkg::TRO_MAXI;
				end else
					cnt_nxt = cnt_r + 1'b1;
			end
			tro_pkg::TRO_MAXI: begin
				imax_nxt = max3(I_L1, I_L2, I_L3);
				st_nxt   = tro_pkg::TRO_AMB;
				cnt_nxt  = cnt_r + 1'b1;
			end
			tro_pkg::TRO_AMB: begin
				kamb_nxt = amb.k_amb;
				st_nxt   = tro_pkg::TRO_RATIO;
				cnt_nxt  = cnt_r + 1'b1;
			end
			tro_pkg::TRO_RATIO: begin
				ratio_nxt = (sq > 48'hFFFFFF) ? 24'hFFFFFF : sq[23:0];
				// Long time constants round to one and must not wrap to zero.
				decay_nxt = (e > 48'h00FFFF) ? 16'hFFFF : e[15:0];
				st_nxt    = tro_pkg::TRO_DECAY;
				cnt_nxt   = cnt_r + 1'b1;
			end
			tro_pkg::TRO_DECAY: begin
				// Same factor for heating and cooling.
				img_nxt = 24'((49'(signed'({1'b0, ratio_r}))
					+ ((d * 49'(signed'({1'b0, decay_r}))) >>> 16)));
				st_nxt  = tro_pkg::TRO_STORE;
				cnt_nxt = cnt_r + 1'b1;
			end
			tro_pkg::TRO_STORE: begin
				done_nxt = 1'b1;
				st_nxt   = tro_pkg::TRO_IDLE;
				cnt_nxt  = cnt_r + 1'b1;
			end
			default: st_nxt = tro_pkg::TRO_IDLE;
		endcase
	end

	always_ff @(posedge CLK) begin
		if (RST) begin
			cnt_r   <= '0;
			st_r    <= tro_pkg::TRO_IDLE;
			imax_r  <= 16'h0000;
			ratio_r <= 24'h000000;
			img_r   <= tro_pkg::IMG_RESET;
			kamb_r  <= tro_pkg::FAC_ONE;
			decay_r <= 16'h0000;
			done_r  <= 1'b0;
		end else if (CE) begin
			cnt_r   <= cnt_nxt;
			st_r    <= st_nxt;
			imax_r  <= imax_nxt;
			ratio_r <= ratio_nxt;
			img_r   <= img_nxt;
			kamb_r  <= kamb_nxt;
			decay_r <= decay_nxt;
			done_r  <= done_nxt;
		end
	end

	always_ff @(posedge CLK) begin
		if (RST) begin
			THERMAL_IMAGE <= 24'h000000;
			K_AMB         <= 16'h0000;
			CYCLE_DONE    <= 1'b0;
		end else if (CE) begin
			THERMAL_IMAGE <= img_r;
			K_AMB         <= kamb_r;
			CYCLE_DONE    <= done_r;
		end
	end

	// Counts enabled cycles between two current samples.
	always_comb begin
		gap_nxt  = gap_r;
		seen_nxt = seen_r;
		if (st_r == tro_pkg::TRO_MAXI) begin
			gap_nxt  = GW'(1);
			seen_nxt = 1'b1;
		end else if (gap_r != '1)
			gap_nxt = gap_r + 1'b1;
	end

	always_ff @(posedge CLK) begin
		if (RST) begin
			gap_r  <= '0;
			seen_r <= 1'b0;
		end else if (CE) begin
			gap_r  <= gap_nxt;
			seen_r <= seen_nxt;
		end
	end

	cycle_period_a: assert property (@(posedge CLK) disable iff (RST)
		CE && st_r == tro_pkg::TRO_MAXI && seen_r
		|-> gap_r == GW'(CYCLE_CLKS))
		else $error("cycle period wrong");
	max_load_a: assert property (@(posedge CLK) disable iff (RST)
		CE && st_r == tro_pkg::TRO_MAXI |=> imax_r >= $past(I_L1)
		&& imax_r >= $past(I_L2) && imax_r >= $past(I_L3))
		else $error("max current wrong");
	no_overshoot_a: assert property (@(posedge CLK) disable iff (RST)
		CE && st_r == tro_pkg::TRO_DECAY && img_r <= ratio_r
		|=> img_r <= ratio_r) else $error("image overshoot");
	cool_down_a: assert property (@(posedge CLK) disable iff (RST)
		CE && st_r == tro_pkg::TRO_DECAY && ratio_r == 24'h000000
		|=> img_r <= $past(img_r)) else $error("cooling rises");
	reset_zero_a: assert property (@(posedge CLK)
		RST |=> img_r == 24'h000000) else $error("reset image");
endmodule
`default_nettype wire

// >>> bench/tro_meas_model.sv
// Model of the three phase current transducers and the ambient sensor.
`timescale 1ns/1ps
`default_nettype none
module tro_meas_model (
	input  wire logic               clk,
	input  wire logic [15:0]        lvl,
	input  wire logic [1:0]         sel,
	input  wire logic [15:0]        rnd,
	input  wire logic signed [11:0] amb,
	output logic [15:0]             i_l1,
	output logic [15:0]             i_l2,
	output logic [15:0]             i_l3,
	output logic signed [11:0]      t_sens
);
	// The selected phase carries the peak, the others a share no larger than it.
	always_ff @(posedge clk) begin
		i_l1 <= (sel == 2'h0) ? lvl : (rnd & lvl);
		i_l2 <= (sel == 2'h1) ? lvl : (rnd & lvl) >> 1;
		i_l3 <= (sel == 2'h2) ? lvl : (rnd & lvl) >> 2;
		t_sens <= amb;
	end
endmodule
`default_nettype wire

// >>> bench/test_thermal_replica_overload.sv
// Self-checking bench of the thermal replica overload filter.
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin n_tests++; if ((got) !== (exp)) begin \
	n_mismatch++; $display("unexpected at %0t: %h vs %h", $time, got, exp); \
	end end
module test_thermal_replica_overload;
	localparam int NC = 20;
	logic               clk = 1'b0, rst = 1'b1, ce = 1'b1, done;
	logic               fix = 1'b0, fahr = 1'b0, crv = 1'b0;
	logic [1:0]         sel = 2'h0;
	logic [3:0]         npts = 4'h2;
	logic [15:0]        lvl = 16'h0000, rnd = 16'h0000, i1, i2, i3, kamb;
	logic [15:0]        inom = 16'h03E8, ksf = 16'h1000, tau = 16'h0000;
	logic [15:0]        kmin = 16'h1A00, kmax = 16'h0600;
	logic signed [11:0] amb = 12'h00F, tset = 12'h00F, tsen;
	logic signed [11:0] tmin = 12'h005, tref = 12'h00F, tmax = 12'h023;
	logic signed [11:0] ct [10];
	logic [15:0]        ck [10];
	logic [23:0]        img, prev;
	logic [31:0]        seed = 32'hAFBB8566;
	int                 n_mismatch = 0, n_tests = 0, cyc = 0, k, v;
	int                 tc [7] = '{-20, 5, 10, 15, 25, 35, 60};
	int                 cn [5] = '{2, 2, 10, 10, 10};
	int                 cx [5] = '{5, 30, 45, 95, -5};
	logic [15:0]        ckx [5] = '{16'h1F80, 16'h1F00, 16'h1B80, 16'h1700,
		16'h2000};

	tro_meas_model tro_meas_model_inst (.clk(clk), .lvl(lvl), .sel(sel),
		.rnd(rnd), .amb(amb), .i_l1(i1), .i_l2(i2), .i_l3(i3), .t_sens(tsen));
	tro_core #(.CYCLE_CLKS(NC)) tro_core_inst (.CLK(clk), .RST(rst),
		.CE(ce), .I_L1(i1), .I_L2(i2), .I_L3(i3), .I_NOM(inom), .K_SF(ksf),
		.TAU_MIN(tau), .AMB_FIXED(fix), .T_SENSOR(tsen), .T_SET(tset),
		.TEMP_FAHR(fahr), .T_MIN(tmin), .T_REF(tref), .T_MAX(tmax),
		.K_MIN(kmin), .K_MAX(kmax), .CURVE_MODE(crv), .CURVE_PTS_USED(npts),
		.CURVE_T(ct), .CURVE_K(ck), .THERMAL_IMAGE(img), .K_AMB(kamb),
		.CYCLE_DONE(done));

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	// Linear ambient factor for the Celsius corner settings used here.
	function automatic logic [15:0] k_lin(input int t);
		int r;
		r = (t <= 5) ? 6656 : (t >= 35) ? 1536 : (t < 15) ?
			6656 - 256 * (t - 5) : 4096 - 128 * (t - 15);
		return 16'(r);
	endfunction

	task automatic close_out;
		if (n_mismatch == 0 && n_tests > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	// Waits for the next image update under a bound.
	task automatic step;
		k = 0;
		do begin @(negedge clk); k++; end while (done !== 1'b1 && k < 60);
		`CHK(done, 1'b1)
	endtask

	initial forever #5 clk = ~clk;

	always @(posedge clk) begin
		seed <= lfsr(seed);
		sel <= 2'(seed[7:0] % 8'h03);
		rnd <= seed[31:16];
		cyc <= cyc + 1;
		if (cyc == 5000) begin n_mismatch++; close_out; end
	end

	initial begin
		for (int i = 0; i < 10; i++) begin
			ct[i] <= 12'(i * 10);
			ck[i] <= 16'(8192 - i * 256);
		end
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		@(negedge clk);
		`CHK(img, 24'h000000)
		step;
		step;
		`CHK(k, NC)
		`CHK(kamb, 16'h1000)
		for (int f = 0; f < 2; f++) foreach (tc[i]) begin
			v = f ? tc[i] * 9 / 5 + 32 : tc[i];
			@(posedge clk);
			fahr <= f[0];
			fix <= i[0];
			tmin <= 12'(f ? 41 : 5);
			tref <= 12'(f ? 59 : 15);
			tmax <= 12'(f ? 95 : 35);
			amb <= i[0] ? 12'h064 : 12'(v);
			tset <= i[0] ? 12'(v) : 12'h064;
			step;
			`CHK(kamb, k_lin(tc[i]))
		end
		foreach (cn[i]) begin
			@(posedge clk);
			crv <= 1'b1;
			fahr <= 1'b0;
			fix <= 1'b1;
			npts <= 4'(cn[i]);
			tset <= 12'(cx[i]);
			step;
			`CHK(kamb, ckx[i])
		end
		@(posedge clk);
		crv <= 1'b0;
		tset <= 12'h00F;
		tmin <= 12'h005;
		tref <= 12'h00F;
		tmax <= 12'h023;
		for (int n = 2; n >= 0; n--) begin
			@(posedge clk);
			lvl <= 16'(n ? 1000 / n : 0);
			step;
			`CHK(img, n ? 24'(6553600 / (n * n)) : 24'h000000)
		end
		@(posedge clk);
		tau <= 16'h0001;
		lvl <= 16'h03E8;
		step;
		`CHK(img >= 24'h0001F4 && img <= 24'h000258, 1'b1)
		for (int h = 0; h < 12; h++) begin
			prev = img;
			@(posedge clk);
			lvl <= (h < 8) ? 16'h03E8 : 16'h0000;
			step;
			`CHK((h < 8) ? (img > prev && img <= 24'h640000) : (img < prev),
				1'b1)
		end
		prev = img;
		@(posedge clk);
		ce <= 1'b0;
		repeat (40) @(negedge clk);
		`CHK(img, prev)
		`CHK(done, 1'b0)
		@(posedge clk);
		ce <= 1'b1;
		step;
		`CHK(img < prev, 1'b1)
		@(posedge clk);
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		@(negedge clk);
		`CHK(img, 24'h000000)
		`CHK(kamb, 16'h0000)
		step;
		`CHK(img, 24'h000000)
		`CHK(kamb, 16'h1000)
		close_out;
	end
endmodule
`default_nettype wire
